/* File: rtl/frame_pkg.sv */
// constants shared by the frame engine and its crc helper
// assumes a byte-wide stream on both client and line side, one clock
package frame_pkg;
  localparam logic [7:0]  PREAMBLE_BYTE    = 8'h55;
  localparam logic [7:0]  SFD_BYTE         = 8'hD5;
  localparam int          PREAMBLE_LEN     = 7;
  localparam logic [15:0] LEN_MAX          = 16'h05DC;  // 1500
  localparam logic [15:0] TYPE_MIN         = 16'h0600;  // 1536
  localparam logic [15:0] TYPE_VLAN        = 16'h8100;
  localparam logic [15:0] TYPE_PAUSE       = 16'h8808;
  localparam int          MIN_FRAME        = 64;
  localparam int          MAX_PAD          = 46;
  localparam int          FCS_LEN          = 4;
  localparam int          HDR_LEN          = 14;
  localparam int          MAX_STD_FRAME    = 1518;
  localparam int          VLAN_EXTRA       = 4;
  localparam logic [31:0] CRC_POLY         = 32'hEDB8_8320;
  localparam logic [31:0] CRC_INIT         = 32'hFFFF_FFFF;
  localparam logic [31:0] CRC_RESIDUE      = 32'hDEBB_20E3;
  localparam logic [31:0] CRC_XOR_OUT      = 32'hFFFF_FFFF;
  localparam int          CNT_W            = 16;
endpackage : frame_pkg

/* File: rtl/crc32_byte.sv */
// one-byte step of the ethernet crc32, reflected form
// assumes the caller holds the running value and feeds one byte per enable
module crc32_byte
  import frame_pkg::*;
(
  input  wire logic [31:0] crc_in,
  input  wire logic [7:0]  data,
  output logic      [31:0] crc_out
);
  always_comb begin
    logic [31:0] c;
    c = crc_in;
    // lsb first, matching the wire bit order
    for (int i = 0; i < 8; i++) begin
      if (c[0] ^ data[i]) begin
        c = (c >> 1) ^ CRC_POLY;
      end else begin
        c = c >> 1;
      end
    end
    crc_out = c;
  end
endmodule : crc32_byte

/* File: rtl/frame_engine.sv */
// ethernet frame engine: transmit framing and receive deframing, byte wide
// assumes the client holds tx data valid through a frame and the line side
// delivers received bytes in wire order with a valid qualifier
module frame_engine
  import frame_pkg::*;
#(
  parameter int MAX_LEN = 65535
) (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       fcs_insert_en,
  input  wire logic       fcs_strip_en,
  input  wire logic       len_check_en,
  input  wire logic       jumbo_en,
  input  wire logic [7:0] tx_data,
  input  wire logic       tx_valid,
  input  wire logic       tx_last,
  output logic            tx_ready,
  output logic [7:0]      line_tx_data,
  output logic            line_tx_valid,
  output logic            line_tx_last,
  input  wire logic [7:0] line_rx_data,
  input  wire logic       line_rx_valid,
  input  wire logic       line_rx_last,
  output logic [7:0]      rx_data,
  output logic            rx_valid,
  output logic            rx_last,
  output logic            rx_bad,
  output logic            rx_len_err,
  output logic            rx_vlan,
  output logic            rx_pause,
  output logic [1:0]      rx_addr_kind
);
  import frame_pkg::*;

  // ************************************************
  // transmit path
  // ************************************************
  typedef enum logic [2:0] {TX_IDLE, TX_PRE, TX_SFD, TX_DATA, TX_PAD, TX_FCS} tx_state_t;
  tx_state_t        tx_st_q;
  logic [CNT_W-1:0] tx_cnt_q;
  logic [31:0]      tx_crc_q;
  logic [31:0]      tx_crc_nx;
  logic [7:0]       tx_byte;
  logic [1:0]       tx_fcs_idx_q;
  logic             tx_take;
  logic             tx_pad_need;

  assign tx_take = (tx_st_q == TX_DATA) && tx_valid;
  // short frame needs pad only when the engine owns the crc
  assign tx_pad_need = fcs_insert_en && (tx_cnt_q < CNT_W'(MIN_FRAME - FCS_LEN - 1));
  assign tx_byte = (tx_st_q == TX_PAD) ? 8'h00 : tx_data;

  crc32_byte u_tx_crc (
    .crc_in  (tx_crc_q),
    .data    (tx_byte),
    .crc_out (tx_crc_nx)
  );

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_st_q      <= TX_IDLE;
      tx_cnt_q     <= '0;
      tx_fcs_idx_q <= '0;
    end else begin
      case (tx_st_q)
        TX_IDLE: begin
          if (tx_valid) begin
            tx_st_q  <= TX_PRE;
            tx_cnt_q <= '0;
          end
        end
        TX_PRE: begin
          if (tx_cnt_q == CNT_W'(PREAMBLE_LEN - 1)) begin
            tx_st_q <= TX_SFD;
          end
          tx_cnt_q <= tx_cnt_q + 1'b1;
        end
        TX_SFD: begin
          tx_st_q  <= TX_DATA;
          tx_cnt_q <= '0;
        end
        TX_DATA: begin
          if (tx_take) begin
            tx_cnt_q <= tx_cnt_q + 1'b1;
            if (tx_last) begin
              if (tx_pad_need) begin
                tx_st_q <= TX_PAD;
              end else if (fcs_insert_en) begin
                tx_st_q      <= TX_FCS;
                tx_fcs_idx_q <= '0;
              end else begin
                tx_st_q <= TX_IDLE;
              end
            end
          end
        end
        TX_PAD: begin
          tx_cnt_q <= tx_cnt_q + 1'b1;
          if (tx_cnt_q == CNT_W'(MIN_FRAME - FCS_LEN - 1)) begin
            tx_st_q      <= TX_FCS;
            tx_fcs_idx_q <= '0;
          end
        end
        TX_FCS: begin
          tx_fcs_idx_q <= tx_fcs_idx_q + 1'b1;
          if (tx_fcs_idx_q == 2'(FCS_LEN - 1)) begin
            tx_st_q <= TX_IDLE;
          end
        end
        default: tx_st_q <= TX_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_crc_q <= CRC_INIT;
    end else if (tx_st_q == TX_SFD) begin
      tx_crc_q <= CRC_INIT;
    end else if (tx_take || tx_st_q == TX_PAD) begin
      tx_crc_q <= tx_crc_nx;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      line_tx_data  <= 8'h00;
      line_tx_valid <= 1'b0;
      line_tx_last  <= 1'b0;
      tx_ready      <= 1'b0;
    end else begin
      line_tx_valid <= 1'b0;
      line_tx_last  <= 1'b0;
      // ready one cycle ahead so the data state takes every offered byte
      tx_ready      <= (tx_st_q == TX_SFD) || (tx_st_q == TX_DATA && !(tx_take && tx_last));
      case (tx_st_q)
        TX_PRE: begin
          line_tx_data  <= PREAMBLE_BYTE;
          line_tx_valid <= 1'b1;
        end
        TX_SFD: begin
          line_tx_data  <= SFD_BYTE;
          line_tx_valid <= 1'b1;
        end
        TX_DATA: begin
          // client bytes go out in order, length/type untouched
          line_tx_data  <= tx_data;
          line_tx_valid <= tx_take;
          line_tx_last  <= tx_take && tx_last && !fcs_insert_en;
        end
        TX_PAD: begin
          line_tx_data  <= 8'h00;
          line_tx_valid <= 1'b1;
        end
        TX_FCS: begin
          // complement then lsb byte first
          line_tx_data  <= tx_crc_q[8*tx_fcs_idx_q +: 8] ^ CRC_XOR_OUT[7:0];
          line_tx_valid <= 1'b1;
          line_tx_last  <= (tx_fcs_idx_q == 2'(FCS_LEN - 1));
        end
        default: begin
          line_tx_data <= 8'h00;
        end
      endcase
    end
  end

  // ************************************************
  // receive path
  // ************************************************
  typedef enum logic [1:0] {RX_HUNT, RX_BODY, RX_DROP} rx_state_t;
  rx_state_t        rx_st_q;
  logic [CNT_W-1:0] rx_cnt_q;
  logic [31:0]      rx_crc_q;
  logic [31:0]      rx_crc_nx;
  logic [15:0]      rx_lt_q;
  logic [CNT_W-1:0] rx_keep_q;
  logic             rx_lt_len_q;
  logic             rx_ones_q;
  // four byte delay so the trailing crc can be held back when stripped
  logic [7:0]       dly_q [FCS_LEN];
  logic [FCS_LEN-1:0] dly_v_q;
  logic             rx_in;
  logic [15:0]      lt_now;
  logic [CNT_W-1:0] out_idx;
  logic             emit;

  assign rx_in  = line_rx_valid && (rx_st_q == RX_BODY);
  assign lt_now = {rx_lt_q[7:0], line_rx_data};

  crc32_byte u_rx_crc (
    .crc_in  (rx_crc_q),
    .data    (line_rx_data),
    .crc_out (rx_crc_nx)
  );

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_st_q <= RX_HUNT;
    end else begin
      case (rx_st_q)
        RX_HUNT: begin
          // preamble bytes are skipped; only the delimiter opens a frame
          if (line_rx_valid && line_rx_data == SFD_BYTE) begin
            rx_st_q <= RX_BODY;
          // a stray byte that ends its own frame leaves the hunt in place
          end else if (line_rx_valid && line_rx_data != PREAMBLE_BYTE && !line_rx_last) begin
            rx_st_q <= RX_DROP;
          end
        end
        RX_BODY: if (line_rx_valid && line_rx_last) rx_st_q <= RX_HUNT;
        RX_DROP: if (line_rx_valid && line_rx_last) rx_st_q <= RX_HUNT;
        default: rx_st_q <= RX_HUNT;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_cnt_q <= '0;
      rx_crc_q <= CRC_INIT;
    end else if (rx_st_q != RX_BODY) begin
      rx_cnt_q <= '0;
      rx_crc_q <= CRC_INIT;
    end else if (line_rx_valid) begin
      // saturate so jumbo frames of any length keep flowing
      // counter stops at the limit; longer frames still flow, only length checks saturate
      if (rx_cnt_q != CNT_W'(MAX_LEN)) rx_cnt_q <= rx_cnt_q + 1'b1;
      rx_crc_q <= rx_crc_nx;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_lt_q      <= '0;
      rx_lt_len_q  <= 1'b0;
      rx_keep_q    <= '1;
      rx_vlan      <= 1'b0;
      rx_pause     <= 1'b0;
      rx_addr_kind <= 2'b00;
      rx_ones_q    <= 1'b0;
    end else if (rx_st_q == RX_HUNT) begin
      rx_keep_q   <= '1;
      rx_lt_len_q <= 1'b0;
    end else if (rx_in) begin
      rx_lt_q <= lt_now;
      if (rx_cnt_q == '0) begin
        rx_addr_kind <= {1'b0, line_rx_data[0]};
        rx_ones_q    <= (line_rx_data == 8'hFF);
      end else if (rx_cnt_q < CNT_W'(6)) begin
        // broadcast only when all six address bytes are ones
        rx_ones_q <= rx_ones_q && (line_rx_data == 8'hFF);
        if (rx_cnt_q == CNT_W'(5) && rx_ones_q && line_rx_data == 8'hFF) begin
          rx_addr_kind <= 2'b11;
        end
      end
      if (rx_cnt_q == CNT_W'(HDR_LEN - 1)) begin
        rx_vlan  <= (lt_now == TYPE_VLAN);
        rx_pause <= (lt_now == TYPE_PAUSE);
        if (lt_now <= LEN_MAX) begin
          rx_lt_len_q <= 1'b1;
          rx_keep_q   <= CNT_W'(HDR_LEN) + lt_now;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      dly_v_q <= '0;
      for (int i = 0; i < FCS_LEN; i++) dly_q[i] <= 8'h00;
    end else if (rx_in) begin
      dly_q[0]   <= line_rx_data;
      dly_v_q[0] <= 1'b1;
      for (int i = 1; i < FCS_LEN; i++) begin
        dly_q[i]   <= dly_q[i-1];
        dly_v_q[i] <= dly_v_q[i-1];
      end
    end else if (rx_st_q == RX_HUNT) begin
      dly_v_q <= '0;
    end
  end

  // index of the byte leaving the delay line when fcs is stripped
  assign out_idx = rx_cnt_q - CNT_W'(FCS_LEN);
  assign emit = fcs_strip_en ? (rx_in && dly_v_q[FCS_LEN-1] &&
                                (!rx_lt_len_q || out_idx < rx_keep_q))
                             : (rx_in && (!rx_lt_len_q || rx_cnt_q < rx_keep_q ||
                                          line_rx_last));

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_data    <= 8'h00;
      rx_valid   <= 1'b0;
      rx_last    <= 1'b0;
      rx_bad     <= 1'b0;
      rx_len_err <= 1'b0;
    end else begin
      // a padded frame may end on a bare last marker so no pad byte leaks out
      rx_valid <= emit;
      rx_last  <= rx_in && line_rx_last;
      // header incl. length/type always forwarded
      rx_data  <= fcs_strip_en ? dly_q[FCS_LEN-1] : line_rx_data;
      if (rx_in && line_rx_last) begin
        // jumbo frames flagged only when the option is off
        rx_bad <= (rx_crc_nx != CRC_RESIDUE) ||
                  (!jumbo_en && !rx_vlan && rx_cnt_q >= CNT_W'(MAX_STD_FRAME)) ||
                  (!jumbo_en && rx_vlan && rx_cnt_q >= CNT_W'(MAX_STD_FRAME + VLAN_EXTRA));
        rx_len_err <= len_check_en && rx_lt_len_q &&
                      (rx_cnt_q + 1'b1 != rx_keep_q + CNT_W'(FCS_LEN)) &&
                      !(rx_keep_q < CNT_W'(MIN_FRAME - FCS_LEN) &&
                        rx_cnt_q + 1'b1 == CNT_W'(MIN_FRAME));
      end else begin
        rx_bad     <= 1'b0;
        rx_len_err <= 1'b0;
      end
    end
  end
endmodule : frame_engine

/* File: test/line_partner.sv */
// line side model: loops framed tx bytes back into the rx path
// assumes the engine's clock; faults only when the bench commands them
module line_partner (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       drop_pre,
  input  wire logic       corrupt,
  input  wire logic [7:0] tx_d,
  input  wire logic       tx_v,
  input  wire logic       tx_l,
  output logic      [7:0] rx_d,
  output logic            rx_v,
  output logic            rx_l
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] n_q;
  logic       pre_q;
  // ****
  // loopback
  // ****
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      {rx_d, rx_v, rx_l, n_q, pre_q} <= {8'h00, 2'h0, 8'h00, 1'b1};
    end else begin
      rx_v <= tx_v && !(drop_pre && pre_q && tx_d != 8'hD5);
      // idle line toggles so a stale byte never looks valid
      rx_d <= tx_v ? tx_d ^ {7'h00, corrupt && !pre_q && n_q == 8'h14} : ~rx_d;
      rx_l <= tx_v && tx_l;
      if (tx_v) begin
        pre_q <= tx_l || (pre_q && tx_d != 8'hD5);
        n_q   <= pre_q ? 8'h00 : n_q + 8'h01;
      end
    end
  end
endmodule : line_partner

/* File: test/frame_engine_assertions.sv */
// checker for the frame engine ports: framing, rx stripping, flag timing
// assumes binding into frame_engine; one clock domain
module frame_engine_assertions
  import frame_pkg::*;
#(
  parameter int MAX_LEN = 65535
) (
  input wire logic       clk,
  input wire logic       arst_n,
  input wire logic       fcs_insert_en,
  input wire logic       len_check_en,
  input wire logic       tx_valid,
  input wire logic [7:0] line_tx_data,
  input wire logic       line_tx_valid,
  input wire logic       line_tx_last,
  input wire logic [7:0] line_rx_data,
  input wire logic       line_rx_valid,
  input wire logic       line_rx_last,
  input wire logic       rx_valid,
  input wire logic       rx_last,
  input wire logic       rx_bad,
  input wire logic       rx_len_err,
  input wire logic [1:0] rx_addr_kind
);
  logic        hunt_q;
  logic        first_q;
  logic        da0_q;
  logic [15:0] tcnt_q;
  // ****
  // helpers
  // ****
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      {hunt_q, first_q, da0_q} <= 3'h4;
    end else if (line_rx_valid) begin
      hunt_q  <= line_rx_last || (hunt_q && line_rx_data != SFD_BYTE);
      first_q <= hunt_q && line_rx_data == SFD_BYTE;
      if (first_q) da0_q <= line_rx_data[0];
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) tcnt_q <= 16'h0000;
    else if (line_tx_valid) tcnt_q <= line_tx_last ? 16'h0000 : tcnt_q + 16'h0001;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  property p_tx_start; $rose(tx_valid) |-> ##[1:2] line_tx_valid; endproperty
  a_tx_start: assert property (p_tx_start) else $error("tx start late");
  property p_preamble; $rose(line_tx_valid) |-> (line_tx_data == PREAMBLE_BYTE)[*7]; endproperty
  a_preamble: assert property (p_preamble) else $error("bad preamble");
  property p_sfd; $rose(line_tx_valid) |-> ##7 line_tx_valid && line_tx_data == SFD_BYTE; endproperty
  a_sfd: assert property (p_sfd) else $error("bad delimiter");
  property p_rx_follows; rx_valid |-> $past(line_rx_valid); endproperty
  a_rx_follows: assert property (p_rx_follows) else $error("rx byte from nothing");
  property p_rx_strip; line_rx_valid && hunt_q |=> !rx_valid; endproperty
  a_rx_strip: assert property (p_rx_strip) else $error("preamble delivered");
  property p_bad_last; rx_bad |-> rx_last; endproperty
  a_bad_last: assert property (p_bad_last) else $error("bad flag off end");
  property p_len_err; rx_len_err |-> rx_last && len_check_en; endproperty
  a_len_err: assert property (p_len_err) else $error("length error misplaced");
  property p_addr_kind; rx_last |-> rx_addr_kind[0] == da0_q; endproperty
  a_addr_kind: assert property (p_addr_kind) else $error("address kind wrong");
  property p_min_len; line_tx_last && fcs_insert_en |-> tcnt_q >= 16'h0047; endproperty
  a_min_len: assert property (p_min_len) else $error("frame too short");
  c_bad: cover property (rx_bad);
  c_len: cover property (rx_len_err);
  c_tx: cover property ($rose(line_tx_valid));
endmodule : frame_engine_assertions

bind frame_engine frame_engine_assertions #(.MAX_LEN(MAX_LEN)) i_frame_engine_assertions (
  .clk, .arst_n, .fcs_insert_en, .len_check_en, .tx_valid, .line_tx_data, .line_tx_valid,
  .line_tx_last, .line_rx_data, .line_rx_valid, .line_rx_last, .rx_valid, .rx_last, .rx_bad,
  .rx_len_err, .rx_addr_kind
);

/* File: test/testbench.sv */
// bench: client frames loop through the line model and come back
// assumes frame_engine and line_partner on one 100 MHz clock
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import frame_pkg::*;
  typedef struct packed {
    logic [7:0]  da0;
    logic [15:0] lt;
    logic [15:0] n;
    logic [5:0]  exp;
  } row_t;
  localparam row_t ROWS [6] = '{'{8'h02, 16'h0800, 16'h002E, 6'h00},
    '{8'h01, 16'h000A, 16'h000A, 6'h01}, '{8'hFF, 16'h8100, 16'h0032, 6'h0B},
    '{8'h03, 16'h8808, 16'h002E, 6'h05}, '{8'h00, 16'h05DC, 16'h05DC, 6'h00},
    '{8'h02, 16'h0600, 16'h0640, 6'h00}};
  logic       clk, arst_n, fcs_insert_en, fcs_strip_en, len_check_en, jumbo_en;
  logic       tx_valid, tx_last, tx_ready, line_tx_valid, line_tx_last, drop_pre, corrupt;
  logic       line_rx_valid, line_rx_last, rx_valid, rx_last, rx_bad, rx_len_err, rx_vlan;
  logic       rx_pause;
  logic [1:0] rx_addr_kind;
  logic [5:0] got;
  logic [7:0] tx_data, line_tx_data, line_rx_data, rx_data;
  logic [7:0] fr[$], ltx[$], rxq[$];
  int         num_errors, checks_done;
  frame_engine #(.MAX_LEN(65535)) i_frame_engine (
    .clk, .arst_n, .fcs_insert_en, .fcs_strip_en, .len_check_en, .jumbo_en, .tx_data,
    .tx_valid, .tx_last, .tx_ready, .line_tx_data, .line_tx_valid, .line_tx_last,
    .line_rx_data, .line_rx_valid, .line_rx_last, .rx_data, .rx_valid, .rx_last, .rx_bad,
    .rx_len_err, .rx_vlan, .rx_pause, .rx_addr_kind
  );
  line_partner i_line_partner (.clk, .arst_n, .drop_pre, .corrupt, .tx_d(line_tx_data),
    .tx_v(line_tx_valid), .tx_l(line_tx_last), .rx_d(line_rx_data), .rx_v(line_rx_valid),
    .rx_l(line_rx_last));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (line_tx_valid === 1'b1) ltx.push_back(line_tx_data);
    if (rx_valid === 1'b1) rxq.push_back(rx_data);
    if (rx_last === 1'b1) got <= {rx_bad, rx_len_err, rx_vlan, rx_pause, rx_addr_kind};
  end
  // ****
  // tasks
  // ****
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic end_of_test;
    if (num_errors == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : end_of_test
  function automatic logic [31:0] crc;
    logic [31:0] c;
    c = CRC_INIT;
    foreach (fr[i]) begin
      c = c ^ {24'h00_0000, fr[i]};
      for (int b = 0; b < 8; b++) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
    end
    return ~c;
  endfunction : crc
  task automatic add_fcs;
    logic [31:0] c;
    c = crc();
    for (int b = 0; b < 4; b++) fr.push_back(c[8 * b +: 8]);
  endtask : add_fcs
  task automatic build(input logic [7:0] da0, input logic [15:0] lt, input int n);
    fr = {};
    for (int i = 0; i < 14 + n; i++)
      fr.push_back(i < 6 ? ((i == 0 || da0 == 8'hFF) ? da0 : 8'h00) : i < 12 ? 8'h10 + 8'(i)
                   : i == 12 ? lt[15:8] : i == 13 ? lt[7:0] : 8'(i) ^ 8'h5A);
  endtask : build
  task automatic send;
    int k;
    ltx = {};
    rxq = {};
    foreach (fr[i]) begin
      {tx_valid, tx_last, tx_data} = {1'b1, i == fr.size() - 1, fr[i]};
      k = 0;
      do begin
        @(posedge clk);
        k++;
      end while (tx_ready !== 1'b1 && k < 200);
      if (tx_ready !== 1'b1) begin
        check(32'h0, 32'h1);
        end_of_test();
      end
      #1;
    end
    {tx_valid, tx_last} = 2'h0;
    for (k = 0; k < 4000 && rx_last !== 1'b1; k++) @(posedge clk);
    if (rx_last !== 1'b1) begin
      check(32'h0, 32'h1);
      end_of_test();
    end
    #1;
  endtask : send
  task automatic chk_rx(input int cnt);
    check(rxq.size(), cnt);
    for (int i = 0; i < cnt; i++) check(rxq[i], fr[i]);
  endtask : chk_rx
  task automatic chk_line(input bit ins);
    if (ins) begin
      while (fr.size() < 60) fr.push_back(8'h00);
      add_fcs();
    end
    check(ltx.size(), fr.size() + 8);
    for (int i = 0; i < fr.size() + 8; i++)
      check(ltx[i], i < 7 ? PREAMBLE_BYTE : i == 7 ? SFD_BYTE : fr[i - 8]);
  endtask : chk_line
  // ****
  // sequence
  // ****
  initial begin
    {num_errors, checks_done} = '0;
    {tx_valid, tx_last, drop_pre, corrupt, len_check_en, arst_n} = '0;
    {fcs_insert_en, fcs_strip_en, jumbo_en} = 3'h7;
    tx_data = 8'h00;
    repeat (10) @(posedge clk);
    check({line_tx_valid, line_tx_last, rx_valid, rx_last, rx_bad, rx_len_err}, 32'h0);
    #1 arst_n = 1'b1;
    foreach (ROWS[r]) begin
      build(ROWS[r].da0, ROWS[r].lt, int'(ROWS[r].n));
      send();
      chk_rx(14 + int'(ROWS[r].lt <= LEN_MAX ? ROWS[r].lt : ROWS[r].n));
      check(got, ROWS[r].exp);
      chk_line(1'b1);
    end
    jumbo_en = 1'b0;
    build(8'h02, 16'h0600, 1600);
    send();
    check(got[5], 1'b1);
    jumbo_en = 1'b1;
    drop_pre = 1'b1;
    build(8'h02, 16'h0800, 46);
    send();
    chk_rx(60);
    {drop_pre, corrupt} = 2'h1;
    send();
    check(got[5], 1'b1);
    {corrupt, len_check_en} = 2'h1;
    build(8'h02, 16'h0064, 50);
    send();
    check(got[4], 1'b1);
    {len_check_en, fcs_strip_en} = 2'h0;
    build(8'h02, 16'h0800, 46);
    send();
    chk_line(1'b1);
    chk_rx(64);
    {fcs_insert_en, fcs_strip_en} = 2'h1;
    build(8'h02, 16'h0800, 46);
    add_fcs();
    send();
    chk_line(1'b0);
    check(got[5], 1'b0);
    end_of_test();
  end
endmodule : testbench
